/* subsample_burst_map.vh */
/*
  Register offsets, field positions, reset values and timing constants
  of the sub-sampling burst sequencer.
  Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
*/
`ifndef SUBSAMPLE_BURST_MAP_VH
`define SUBSAMPLE_BURST_MAP_VH

// Register byte offsets
`define REG_CTRL       6'h00
`define REG_CMD        6'h04
`define REG_EFF_NS     6'h08
`define REG_COUNT      6'h0c
`define REG_DELAY_NS   6'h10
`define REG_LEVEL      6'h14
`define REG_MAXIN_MV   6'h18
`define REG_READINGS   6'h1c
`define REG_STATUS     6'h20
`define REG_PLAN_FULL  6'h24
`define REG_PLAN_LESS  6'h28
`define REG_PLAN_N     6'h2c
`define REG_MEM_COUNT  6'h30
`define REG_MEM_DATA   6'h34

// Control register fields
`define CTRL_SUBSAMPLE 0
`define CTRL_DC        1
`define CTRL_SYNC_EXT  2
`define CTRL_SLOPE_NEG 3
`define CTRL_OFMT_LO   4
`define CTRL_MFMT_LO   6
`define CTRL_MEM_EN    8
`define CTRL_RESET     9'h000

// Command register fields
`define CMD_ARM        0
`define CMD_FIFO       1
`define CMD_CLR_ERR    2

// Sample formats
`define FMT_SHORT_INTEGER_FORMAT       2'h0
`define FMT_DOUBLE_INTEGER_FORMAT       2'h1
`define FMT_DOUBLE_REAL_FORMAT      2'h2

// Timing, in nanoseconds
`define CLK_PERIOD_NS  32'h0000000a
`define MIN_EFF_NS     32'h0000000a
`define MIN_CONV_NS    32'h00004e20

// Range thresholds on the maximum input, in millivolts
`define MAXIN_10MV     32'h0000000c
`define MAXIN_100MV    32'h00000078
`define MAXIN_1V       32'h000004b0
`define MAXIN_10V      32'h00002ee0
`define MAXIN_100V     32'h0001d4c0
`define MAXIN_1KV      32'h000f4240

// Level limit (500 %) and short-integer span (120 %), in 0.1 % of range
`define LEVEL_LIMIT    16'h1388
`define SHORT_INTEGER_FORMAT_SPAN      16'h04b0
`define SHORT_INTEGER_FORMAT_POS_SAT   16'h7fff
`define SHORT_INTEGER_FORMAT_NEG_SAT   16'h8001

`endif

/* subsample_burst_sequencer.v */
/*
  Sub-sampling burst sequencer: plans bursts, waits for sync events, times
  conversions and stores samples in composite-waveform order.
  Assumes all inputs synchronous to i_clk and an Avalon-MM master on the bus.
*/
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
// How it works
// - Bursts and samples per burst are worked out from interval and count.
// - Each later burst starts one more effective interval after its sync.
// - Bursts start on sync events and repeat until all samples are taken.
// - External sync fires on a falling edge of the trigger input.
// - After reset the level-crossing sync source is selected.
// - Only the arm event and sync event steer acquisition.
// - Sync events count only after the arm event.
// - The per-trigger reading count is refused while sub-sampling.
// - Effective intervals down to ten nanoseconds are accepted.
// - Within a burst, real conversions stay at least twenty microseconds apart.
// - A fixed range is picked from the maximum input by decade thresholds.
// - Level may reach 500 percent; short-integer samples clip at 120 percent.
// - Entering sub-sampling with memory off forces short-integer output format; leaving it restores it.
// - Entering with memory on leaves the output format alone.
// - At arm with memory on, memory must be FIFO, empty and short integer, else error.
// - Selecting FIFO mode clears the memory.
// - The programmed delay lies between sync and first sample; reset value zero.
// - Samples go to memory in composite-waveform order.
// - AC-coupled and DC-coupled sub-sampling are both offered.
// - Full bursts, short bursts and samples per full burst are readable.
// - Intervals of twenty microseconds or more give one direct burst.
// - A host too slow for the sample stream raises the overrun error.
`include "subsample_burst_map.vh"

module subsample_burst_sequencer #(
  parameter MEM_DEPTH = 64,
  parameter AW = 6
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Avalon-MM slave
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // Sync sources
  input wire i_ext_trig,
  input wire signed [15:0] i_input_level,
  // Converter
  output reg o_convert,
  input wire i_conv_valid,
  input wire signed [15:0] i_conv_data,
  // Front-end setup
  output reg [2:0] o_range,
  output wire o_dc_coupled,
  output wire o_subsample_active,
  output wire [1:0] o_output_format,
  // Direct stream to host
  output reg [15:0] o_host_data,
  output reg o_host_valid,
  input wire i_host_ready
);

  // One-hot acquisition states
  localparam S_IDLE = 3'b001;
  localparam S_SYNC = 3'b010;
  localparam S_RUN = 3'b100;
  // One-hot planning states
  localparam P_IDLE = 3'b001;
  localparam P_BURST = 3'b010;
  localparam P_SAMP = 3'b100;

  reg ack;
  reg [8:0] ctrl;
  reg [31:0] eff_ns;
  reg [31:0] count;
  reg [31:0] delay_ns;
  reg signed [15:0] level;
  reg [31:0] maxin_mv;
  reg [31:0] readings;
  reg setup_err;
  reg overrun_err;
  reg refused;
  reg fifo_mode;
  reg fmt_forced;
  reg [2:0] pstate;
  reg [31:0] plan_acc;
  reg [31:0] plan_b;
  reg [31:0] plan_n;
  reg [31:0] plan_full;
  reg [31:0] plan_less;
  reg [31:0] period_ns;
  reg [2:0] state;
  reg [31:0] burst;
  reg [31:0] samp;
  reg [31:0] taken;
  reg [31:0] ns_cnt;
  reg [31:0] target;
  reg [31:0] offset_ns;
  reg [31:0] wr_addr;
  reg [31:0] pend_addr;
  reg [15:0] mem [0:MEM_DEPTH-1];
  reg [AW:0] mem_count;
  reg [AW-1:0] rd_ptr;
  reg ext_prev;
  reg signed [15:0] lvl_prev;
  reg [15:0] clipped;
  reg [2:0] next_range;
  integer k;

  wire wr_ok = i_avs_write & ack;
  wire rd_ok = i_avs_read & ack;
  wire subsample = ctrl[`CTRL_SUBSAMPLE];
  wire mem_en = ctrl[`CTRL_MEM_EN];
  wire [1:0] mfmt = ctrl[`CTRL_MFMT_LO+1:`CTRL_MFMT_LO];
  wire arm = wr_ok & (i_avs_address == `REG_CMD) & i_avs_writedata[`CMD_ARM];
  wire fifo_sel = wr_ok & (i_avs_address == `REG_CMD) & i_avs_writedata[`CMD_FIFO];
  wire busy = (state != S_IDLE) | (pstate != P_IDLE);
  wire [31:0] burst_len = (burst < plan_full) ? plan_n : plan_n - 32'h1;
  wire last_samp = (samp + 32'h1 == burst_len);
  wire ext_fall = ext_prev & ~i_ext_trig;
  wire lvl_cross = ctrl[`CTRL_SLOPE_NEG] ?
                   (lvl_prev > level) & (i_input_level <= level) :
                   (lvl_prev < level) & (i_input_level >= level);
  // External falling edge or level crossing, as the source select says
  wire sync_evt = ctrl[`CTRL_SYNC_EXT] ? ext_fall : lvl_cross;
  wire [15:0] abs_lvl = i_avs_writedata[15] ? 16'h0 - i_avs_writedata[15:0] : i_avs_writedata[15:0];
  wire [15:0] abs_conv = i_conv_data[15] ? 16'h0 - i_conv_data : i_conv_data;

  // One wait state on every access; answer comes at the second edge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign o_dc_coupled = ctrl[`CTRL_DC];
  assign o_subsample_active = subsample;
  // Short integer while forced, otherwise the stored selection comes back
  assign o_output_format = fmt_forced ? `FMT_SHORT_INTEGER_FORMAT : ctrl[`CTRL_OFMT_LO+1:`CTRL_OFMT_LO];

  // Range from maximum input by decade thresholds
  always @* begin
    if (maxin_mv <= `MAXIN_10MV) begin
      next_range = 3'h0;
    end else if (maxin_mv <= `MAXIN_100MV) begin
      next_range = 3'h1;
    end else if (maxin_mv <= `MAXIN_1V) begin
      next_range = 3'h2;
    end else if (maxin_mv <= `MAXIN_10V) begin
      next_range = 3'h3;
    end else if (maxin_mv <= `MAXIN_100V) begin
      next_range = 3'h4;
    end else begin
      next_range = 3'h5;
    end
  end

  // Short-integer clipping beyond 120 percent of range
  always @* begin
    if (abs_conv > `SHORT_INTEGER_FORMAT_SPAN) begin
      clipped = i_conv_data[15] ? `SHORT_INTEGER_FORMAT_NEG_SAT : `SHORT_INTEGER_FORMAT_POS_SAT;
    end else begin
      clipped = i_conv_data;
    end
  end

  // Bus handshake and register writes
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      ack <= 1'b0;
      ctrl <= `CTRL_RESET;
      eff_ns <= `MIN_CONV_NS;
      count <= 32'h0;
      delay_ns <= 32'h0;
      level <= 16'h0;
      maxin_mv <= `MAXIN_10V;
      readings <= 32'h1;
      refused <= 1'b0;
      fmt_forced <= 1'b0;
      o_range <= 3'h3;
    end else begin
      ack <= (i_avs_read | i_avs_write) & ~ack;
      o_range <= next_range;
      if (wr_ok && !busy) begin
        case (i_avs_address)
          `REG_CTRL: begin
            ctrl <= i_avs_writedata[8:0];
            // Entering the mode with memory off forces short integer output
            if (i_avs_writedata[`CTRL_SUBSAMPLE] && !subsample && !i_avs_writedata[`CTRL_MEM_EN]) begin
              fmt_forced <= 1'b1;
            end else if (!i_avs_writedata[`CTRL_SUBSAMPLE]) begin
              fmt_forced <= 1'b0;
            end
          end
          `REG_EFF_NS: begin
            if (i_avs_writedata >= `MIN_EFF_NS) begin
              eff_ns <= i_avs_writedata;
            end
          end
          `REG_COUNT: count <= i_avs_writedata;
          `REG_DELAY_NS: delay_ns <= i_avs_writedata;
          `REG_LEVEL: begin
            if (abs_lvl <= `LEVEL_LIMIT) begin
              level <= i_avs_writedata[15:0];
            end
          end
          `REG_MAXIN_MV: maxin_mv <= i_avs_writedata;
          `REG_READINGS: begin
            if (subsample) begin
              refused <= 1'b1;
            end else begin
              readings <= i_avs_writedata;
            end
          end
          `REG_CMD: begin
            if (i_avs_writedata[`CMD_CLR_ERR]) begin
              refused <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data, captured at the edge that ends the wait state
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack) begin
      case (i_avs_address)
        `REG_CTRL: o_avs_readdata <= {23'h0, ctrl};
        `REG_EFF_NS: o_avs_readdata <= eff_ns;
        `REG_COUNT: o_avs_readdata <= count;
        `REG_DELAY_NS: o_avs_readdata <= delay_ns;
        `REG_LEVEL: o_avs_readdata <= {{16{level[15]}}, level};
        `REG_MAXIN_MV: o_avs_readdata <= maxin_mv;
        `REG_READINGS: o_avs_readdata <= readings;
        `REG_STATUS: o_avs_readdata <= {21'h0, fifo_mode, o_output_format, o_range, refused,
                                        overrun_err, setup_err, pstate != P_IDLE, state != S_IDLE};
        `REG_PLAN_FULL: o_avs_readdata <= plan_full;
        `REG_PLAN_LESS: o_avs_readdata <= plan_less;
        `REG_PLAN_N: o_avs_readdata <= plan_n;
        `REG_MEM_COUNT: o_avs_readdata <= {{(31-AW){1'b0}}, mem_count};
        `REG_MEM_DATA: o_avs_readdata <= {16'h0, mem[rd_ptr]};
        default: o_avs_readdata <= 32'h0;
      endcase
    end
  end

  // Burst planner, started by the arm event
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      pstate <= P_IDLE;
      plan_acc <= 32'h0;
      plan_b <= 32'h1;
      plan_n <= 32'h0;
      plan_full <= 32'h0;
      plan_less <= 32'h0;
      period_ns <= `MIN_CONV_NS;
    end else begin
      case (pstate)
        P_IDLE: begin
          if (arm && state == S_IDLE && subsample) begin
            plan_acc <= eff_ns;
            plan_b <= 32'h1;
            pstate <= P_BURST;
          end
        end
        P_BURST: begin
          // Fewest bursts that keep conversions 20 us apart; 1 means direct
          if (plan_acc < `MIN_CONV_NS) begin
            plan_acc <= plan_acc + eff_ns;
            plan_b <= plan_b + 32'h1;
          end else begin
            period_ns <= plan_acc;
            plan_acc <= plan_b;
            plan_n <= 32'h1;
            pstate <= P_SAMP;
          end
        end
        P_SAMP: begin
          // Smallest N with bursts times N covering the count
          if (plan_acc < count) begin
            plan_acc <= plan_acc + plan_b;
            plan_n <= plan_n + 32'h1;
          end else begin
            plan_full <= count + plan_b - plan_acc;
            plan_less <= plan_acc - count;
            pstate <= P_IDLE;
          end
        end
        default: pstate <= P_IDLE;
      endcase
    end
  end

  // Acquisition: arm, then one burst per sync event
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      state <= S_IDLE;
      burst <= 32'h0;
      samp <= 32'h0;
      taken <= 32'h0;
      ns_cnt <= 32'h0;
      target <= 32'h0;
      offset_ns <= 32'h0;
      wr_addr <= 32'h0;
      pend_addr <= 32'h0;
      setup_err <= 1'b0;
      o_convert <= 1'b0;
    end else begin
      o_convert <= 1'b0;
      if (wr_ok && i_avs_address == `REG_CMD && i_avs_writedata[`CMD_CLR_ERR]) begin
        setup_err <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (arm && subsample && pstate == P_IDLE) begin
            // With memory on, it must be FIFO, empty and short integer at arm time
            if (mem_en && (!fifo_mode || mem_count != 0 || mfmt != `FMT_SHORT_INTEGER_FORMAT)) begin
              setup_err <= 1'b1;
            end else if (count != 32'h0) begin
              burst <= 32'h0;
              samp <= 32'h0;
              taken <= 32'h0;
              offset_ns <= 32'h0;
              state <= S_SYNC;
            end
          end
        end
        S_SYNC: begin
          // Planner finishes long before any real sync period elapses
          if (sync_evt && pstate == P_IDLE) begin
            ns_cnt <= 32'h0;
            target <= delay_ns + offset_ns;
            wr_addr <= burst;
            samp <= 32'h0;
            state <= S_RUN;
          end
        end
        S_RUN: begin
          ns_cnt <= ns_cnt + `CLK_PERIOD_NS;
          if (ns_cnt >= target) begin
            o_convert <= 1'b1;
            pend_addr <= wr_addr;
            target <= target + period_ns;
            wr_addr <= wr_addr + plan_b;
            samp <= samp + 32'h1;
            taken <= taken + 32'h1;
            if (taken + 32'h1 == count) begin
              state <= S_IDLE;
            end else if (last_samp) begin
              burst <= burst + 32'h1;
              offset_ns <= offset_ns + eff_ns;
              state <= S_SYNC;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Sync edge and level history
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      ext_prev <= 1'b0;
      lvl_prev <= 16'h0;
    end else begin
      ext_prev <= i_ext_trig;
      lvl_prev <= i_input_level;
    end
  end

  // Reading memory: composite-order writes, FIFO reads
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      mem_count <= {(AW+1){1'b0}};
      rd_ptr <= {AW{1'b0}};
      fifo_mode <= 1'b0;
      for (k = 0; k < MEM_DEPTH; k = k + 1) begin
        mem[k] <= 16'h0;
      end
    end else if (fifo_sel && !busy) begin
      fifo_mode <= 1'b1;
      mem_count <= {(AW+1){1'b0}};
      rd_ptr <= {AW{1'b0}};
    end else begin
      if (i_conv_valid && mem_en && pend_addr < MEM_DEPTH) begin
        mem[pend_addr[AW-1:0]] <= clipped;
        mem_count <= mem_count + 1'b1;
      end else if (rd_ok && i_avs_address == `REG_MEM_DATA && mem_count != 0) begin
        rd_ptr <= rd_ptr + 1'b1;
        mem_count <= mem_count - 1'b1;
      end
    end
  end

  // Direct stream to host; a sample with the last one unaccepted overruns
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_host_data <= 16'h0;
      o_host_valid <= 1'b0;
      overrun_err <= 1'b0;
    end else begin
      // Clear first so an overrun in the same cycle still sets the flag
      if (wr_ok && i_avs_address == `REG_CMD && i_avs_writedata[`CMD_CLR_ERR]) begin
        overrun_err <= 1'b0;
      end
      if (i_conv_valid && !mem_en) begin
        if (o_host_valid && !i_host_ready) begin
          overrun_err <= 1'b1;
        end else begin
          o_host_data <= clipped;
          o_host_valid <= 1'b1;
        end
      end else if (i_host_ready) begin
        o_host_valid <= 1'b0;
      end
    end
  end

endmodule

/* subsample_burst_checker_props.sv */
/*
  Checker for the sub-sampling burst sequencer: bus handshake, conversion pacing,
  host stream hand-off and mode outputs.
  Assumes it is bound to the sequencer top and sees only that module's ports.
*/
`timescale 1ns/1ns
module subsample_burst_checker (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Register bus
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  // Converter
  input wire o_convert,
  input wire i_conv_valid,
  // Host stream
  input wire [15:0] o_host_data,
  input wire o_host_valid,
  input wire i_host_ready,
  // Front-end setup
  input wire o_dc_coupled,
  input wire o_subsample_active
);
  reg [15:0] gap;

  // Cycles since the last conversion, saturating so the first one always passes
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      gap <= 16'hffff;
    end else if (o_convert) begin
      gap <= 16'h0001;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Bus answers after exactly one wait state and never stalls when idle
  a_wait_one_cycle: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("waitrequest not one cycle");
  a_idle_no_wait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest while idle");
  // Conversions are single pulses at most 50k per second
  a_convert_pulse: assert property (o_convert |=> !o_convert)
    else $error("convert longer than one cycle");
  a_conv_spacing: assert property (o_convert |-> gap >= 16'd2000)
    else $error("conversions closer than 20 us");
  a_convert_mode: assert property (o_convert |-> o_subsample_active)
    else $error("conversion outside sub-sampling");
  // Host stream holds its word until taken, and only after a result
  a_host_hold: assert property (o_host_valid && !i_host_ready |=> o_host_valid && $stable(o_host_data))
    else $error("host word not held");
  a_host_cause: assert property ($rose(o_host_valid) |-> $past(i_conv_valid))
    else $error("host word without result");
  // Mode outputs move only on register writes
  a_mode_by_write: assert property ($changed(o_subsample_active) |-> $past(i_avs_write))
    else $error("mode changed without write");
  a_coupling_write: assert property ($changed(o_dc_coupled) |-> $past(i_avs_write))
    else $error("coupling changed without write");
endmodule

bind subsample_burst_sequencer subsample_burst_checker u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_convert(o_convert), .i_conv_valid(i_conv_valid),
  .o_host_data(o_host_data), .o_host_valid(o_host_valid), .i_host_ready(i_host_ready),
  .o_dc_coupled(o_dc_coupled), .o_subsample_active(o_subsample_active)
);

/* subsample_front_end_model.sv */
/*
  Front-end model: a converter that answers each start with a numbered result,
  and a periodic sawtooth input for the level sync source.
  Assumes starts are single-cycle pulses spaced wider than the latency.
*/
`timescale 1ns/1ns
module subsample_front_end_model #(
  parameter [3:0] LAT = 4'h3
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Converter handshake
  input wire i_convert,
  output reg o_conv_valid,
  output reg [15:0] o_conv_data,
  // Periodic input, one rising zero crossing every 5000 cycles
  output reg [15:0] o_input_level
);
  reg [3:0] busy;
  reg [15:0] taken;
  reg [15:0] phase;

  // Result is 0x100 plus the start number; idle data toggles every cycle
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      busy <= 4'h0;
      taken <= 16'h0000;
      phase <= 16'h0000;
      o_conv_valid <= 1'b0;
      o_conv_data <= 16'h5a5a;
      o_input_level <= 16'h0000;
    end else begin
      o_conv_valid <= 1'b0;
      o_conv_data <= ~o_conv_data;
      phase <= (phase == 16'd4999) ? 16'h0000 : phase + 16'h0001;
      o_input_level <= phase - 16'd2500;
      if (i_convert) begin
        busy <= LAT;
      end else if (busy != 4'h0) begin
        busy <= busy - 4'h1;
        if (busy == 4'h1) begin
          o_conv_valid <= 1'b1;
          o_conv_data <= 16'h0100 + taken;
          taken <= taken + 16'h0001;
        end
      end
    end
  end
endmodule

/* subsample_burst_sequencer_tb_top.sv */
/*
  Testbench of the sub-sampling burst sequencer: registers, planning, burst timing,
  memory order, setup errors and the host stream.
  Assumes the front-end model answers every conversion start.
*/
`timescale 1ns/1ns
`include "subsample_burst_map.vh"
module subsample_burst_sequencer_tb_top;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [5:0] addr = 6'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg ext = 1'b1;
  reg hready = 1'b1;
  wire [31:0] rdata;
  wire wreq, conv, cvalid, dc, ssa, hvalid;
  wire [15:0] cdata, lvl, hdata;
  wire [2:0] rng;
  wire [1:0] ofmt;
  reg [31:0] q;
  integer error_cnt = 0, checks = 0, cyc = 0, nconv = 0, i, d;
  integer conv_t [0:15];
  integer sync_t [0:3];
  reg [31:0] mx [0:6] = '{32'hc, 32'hd, 32'h78, 32'h4b0, 32'h2ee0, 32'h1d4c0, 32'h1d4c1};
  reg [2:0] rc [0:6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  integer first [0:3] = '{0, 2, 4, 5};
  integer order [0:5] = '{0, 2, 4, 5, 1, 3};

  subsample_burst_sequencer u_dut (
    .i_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_ext_trig(ext),
    .i_input_level(lvl), .o_convert(conv), .i_conv_valid(cvalid), .i_conv_data(cdata),
    .o_range(rng), .o_dc_coupled(dc), .o_subsample_active(ssa), .o_output_format(ofmt),
    .o_host_data(hdata), .o_host_valid(hvalid), .i_host_ready(hready));
  subsample_front_end_model u_fe (
    .i_clk(clk), .i_rstn(rstn), .i_convert(conv), .o_conv_valid(cvalid), .o_conv_data(cdata),
    .o_input_level(lvl));

  // Clock and a log of the first 16 conversion starts
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv === 1'b1 && nconv < 16) begin
      conv_t[nconv] <= cyc;
      nconv <= nconv + 1;
    end
  end

  task end_sim;
    begin
      if (error_cnt == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low
  task bus(input w, input [5:0] a, input [31:0] dt);
    integer n;
    begin
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= dt;
      n = 0;
      @(posedge clk);
      while (wreq !== 1'b0 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n == 50) begin
        chk("timeout", 32'h0, 32'h1);
        end_sim;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  task rd_chk(input string name, input [5:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(name, exp, q);
    end
  endtask

  // Poll status until the masked busy bits clear
  task wait_clear(input [31:0] m);
    integer n;
    begin
      n = 0;
      bus(1'b0, `REG_STATUS, 32'h0);
      while ((q & m) !== 32'h0 && n < 400) begin
        repeat (50) @(posedge clk);
        bus(1'b0, `REG_STATUS, 32'h0);
        n = n + 1;
      end
      if (n == 400) begin
        chk("timeout", 32'h0, 32'h1);
        end_sim;
      end
    end
  endtask

  // Falling edge on the external trigger, then the rest of one input period
  task sync_pulse(input integer b);
    begin
      @(posedge clk);
      ext <= 1'b0;
      sync_t[b] = cyc;
      repeat (10) @(posedge clk);
      ext <= 1'b1;
      repeat (4990) @(posedge clk);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_chk("ctrl", `REG_CTRL, 32'h0);
    rd_chk("eff", `REG_EFF_NS, 32'h4e20);
    rd_chk("delay", `REG_DELAY_NS, 32'h0);
    rd_chk("readings", `REG_READINGS, 32'h1);
    rd_chk("status", `REG_STATUS, 32'h60);
    rd_chk("unmapped", 6'h3c, 32'h0);
    for (i = 0; i < 7; i = i + 1) begin
      bus(1'b1, `REG_MAXIN_MV, mx[i]);
      repeat (3) @(posedge clk);
      chk("range", {29'h0, rc[i]}, {29'h0, rng});
    end
    bus(1'b1, `REG_EFF_NS, 32'h9);
    rd_chk("eff low", `REG_EFF_NS, 32'h4e20);
    bus(1'b1, `REG_EFF_NS, 32'ha);
    rd_chk("eff min", `REG_EFF_NS, 32'ha);
    bus(1'b1, `REG_LEVEL, 32'h1389);
    bus(1'b1, `REG_LEVEL, 32'h1388);
    rd_chk("level", `REG_LEVEL, 32'h1388);
    // Format forcing, coupling and refused reading count
    bus(1'b1, `REG_CTRL, 32'h23);
    repeat (2) @(posedge clk);
    chk("fmt forced", 32'h0, {30'h0, ofmt});
    chk("dc", 32'h1, {31'h0, dc});
    chk("active", 32'h1, {31'h0, ssa});
    bus(1'b1, `REG_READINGS, 32'h5);
    rd_chk("readings", `REG_READINGS, 32'h1);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("refused", 32'h1, {31'h0, q[4]});
    bus(1'b1, `REG_CTRL, 32'h21);
    repeat (2) @(posedge clk);
    chk("ac", 32'h0, {31'h0, dc});
    bus(1'b1, `REG_CTRL, 32'h20);
    repeat (2) @(posedge clk);
    chk("fmt restored", 32'h2, {30'h0, ofmt});
    bus(1'b1, `REG_CTRL, 32'h111);
    repeat (2) @(posedge clk);
    chk("fmt kept", 32'h1, {30'h0, ofmt});
    // Wrong memory format at arm: error and no samples
    bus(1'b1, `REG_CTRL, 32'h145);
    bus(1'b1, `REG_COUNT, 32'h6);
    bus(1'b1, `REG_EFF_NS, 32'h1388);
    bus(1'b1, `REG_DELAY_NS, 32'h1f4);
    bus(1'b1, `REG_CMD, 32'h2);
    bus(1'b1, `REG_CMD, 32'h1);
    sync_pulse(0);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("setup err", 32'h1, {31'h0, q[2]});
    chk("no samples", 32'h0, nconv);
    bus(1'b1, `REG_CMD, 32'h4);
    bus(1'b1, `REG_CTRL, 32'h105);
    bus(1'b1, `REG_CMD, 32'h2);
    rd_chk("mem empty", `REG_MEM_COUNT, 32'h0);
    sync_pulse(0);
    chk("unarmed", 32'h0, nconv);
    bus(1'b1, `REG_CMD, 32'h1);
    wait_clear(32'h2);
    chk("err cleared", 32'h0, {31'h0, q[2]});
    rd_chk("full", `REG_PLAN_FULL, 32'h2);
    rd_chk("less", `REG_PLAN_LESS, 32'h2);
    rd_chk("n", `REG_PLAN_N, 32'h2);
    for (i = 0; i < 4; i = i + 1)
      sync_pulse(i);
    wait_clear(32'h1);
    chk("conversions", 32'h6, nconv);
    for (i = 0; i < 4; i = i + 1) begin
      d = conv_t[first[i]] - sync_t[i] - (50 + 500 * i);
      chk("burst offset", 32'h1, {31'h0, d >= 0 && d <= 5});
    end
    for (i = 0; i < 3; i = i + 2) begin
      d = conv_t[i + 1] - conv_t[i];
      chk("spacing", 32'h1, {31'h0, d >= 2000 && d <= 2001});
    end
    rd_chk("mem count", `REG_MEM_COUNT, 32'h6);
    for (i = 0; i < 6; i = i + 1)
      rd_chk("composite", `REG_MEM_DATA, 32'h100 + order[i]);
    // Host stream on the level source with a stalled host
    hready <= 1'b0;
    bus(1'b1, `REG_CTRL, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h21);
    bus(1'b1, `REG_LEVEL, 32'h0);
    bus(1'b1, `REG_EFF_NS, 32'h2710);
    bus(1'b1, `REG_COUNT, 32'h2);
    bus(1'b1, `REG_DELAY_NS, 32'h0);
    bus(1'b1, `REG_CMD, 32'h1);
    wait_clear(32'h2);
    rd_chk("full", `REG_PLAN_FULL, 32'h2);
    rd_chk("less", `REG_PLAN_LESS, 32'h0);
    wait_clear(32'h1);
    // Let the last result arrive before looking at the overrun flag
    repeat (10) @(posedge clk);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("overrun", 32'h1, {31'h0, q[3]});
    chk("host data", 32'h106, {16'h0, hdata});
    chk("host fmt", 32'h0, {30'h0, ofmt});
    hready <= 1'b1;
    repeat (2) @(posedge clk);
    chk("host taken", 32'h0, {31'h0, hvalid});
    // An interval of 20 us or more plans one direct burst
    bus(1'b1, `REG_EFF_NS, 32'h4e20);
    bus(1'b1, `REG_COUNT, 32'h3);
    bus(1'b1, `REG_CMD, 32'h1);
    wait_clear(32'h2);
    rd_chk("direct full", `REG_PLAN_FULL, 32'h1);
    rd_chk("direct n", `REG_PLAN_N, 32'h3);
    end_sim;
  end
endmodule
